// file: design/bscd_core.sv
`timescale 1ns/10ps
`default_nettype none
module bscd_core
   import bscd_pkg::*;
#(
   parameter int PROG_DEPTH   = 256,
   parameter int STACK_DEPTH  = 8,
   parameter int WDOG_PRESC_W = 8
)(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   localparam int PROG_AW = $clog2(PROG_DEPTH);
   localparam int SP_W    = $clog2(STACK_DEPTH);
   localparam logic [9:0] PROG_LIMIT = 10'(PROG_DEPTH);

   // Storage
   logic [13:0]           progMem  [PROG_DEPTH];
   logic [7:0]            fileMem  [128];
   logic [12:0]           stackMem [STACK_DEPTH];

   // Core state
   logic                  running;
   logic [1:0]            phase;
   logic [12:0]           pc;
   logic [13:0]           instrReg;
   logic                  instrValid;
   logic [7:0]            wReg;
   logic                  zeroFlag;
   logic                  timeoutFlag;
   logic                  powerdownFlag;
   logic [4:0]            pcLatch;
   logic [7:0]            wdogCount;
   logic [WDOG_PRESC_W-1:0] wdogPresc;
   logic [SP_W-1:0]       sp;

   // Bus state
   logic                  awHeld;
   logic                  wHeld;
   logic [11:0]           awAddrQ;
   logic [31:0]           wDataQ;
   logic [3:0]            wStrbQ;

   // Decode of the instruction in execute
   bscd_op_t              op;
   logic [6:0]            fileAddr;
   logic [2:0]            bitSel;
   logic                  destFile;
   logic [10:0]           callTarget;

   bscd_decode bscd_decode_inst (
      .instr      (instrReg),
      .op         (op),
      .fileAddr   (fileAddr),
      .bitSel     (bitSel),
      .destFile   (destFile),
      .callTarget (callTarget)
   );

   // Four oscillator periods make one instruction cycle
   wire cycleEnd  = running && (phase == PHASE_LAST);  // see RQ16
   // A discarded slot has instrValid low and runs as a no-operation
   wire execValid = cycleEnd && instrValid;

   wire isClrBit   = execValid && (op == BIT_CLEAR_OP);
   wire isSetBit   = execValid && (op == BIT_SET_OP);
   wire isTestZero = execValid && (op == TEST_SKIP_IF_ZERO_OP);
   wire isTestOne  = execValid && (op == TEST_SKIP_IF_ONE_OP);
   wire isCall     = execValid && (op == CALL_OP);
   wire isClrAcc   = execValid && (op == CLEAR_ACCUMULATOR_OP);
   wire isClrFile  = execValid && (op == CLEAR_FILE_OP);
   wire isWdogClr  = execValid && (op == WATCHDOG_CLEAR_OP);
   wire isInvert   = execValid && (op == INVERT_FILE_OP);
   wire isDecSkip  = execValid && (op == DECREMENT_SKIP_ZERO_OP);
   wire isByteOp   = isInvert || isDecSkip;

   // Operand read in the same cycle that decides the skip
   wire [7:0] fileRd = fileMem[fileAddr];                  // see RQ17
   wire       bitVal = fileRd[bitSel];
   wire [7:0] invRes = ~fileRd;                            // see RQ11
   wire [7:0] decRes = fileRd - 8'h01;                     // see RQ13
   wire [7:0] aluRes = isInvert ? invRes : decRes;

   wire skipNow = (isTestZero && !bitVal)                  // see RQ4
               || (isTestOne && bitVal)                    // see RQ5
               || (isDecSkip && (decRes == 8'h00));        // see RQ14

   wire       fileWe    = isClrBit || isSetBit || isClrFile
                       || (isByteOp && destFile);          // see RQ12
   wire [7:0] fileWdata =
      isClrBit  ? (fileRd & ~bitMask(bitSel)) :            // see RQ1
      isSetBit  ? (fileRd | bitMask(bitSel)) :             // see RQ2
      isClrFile ? 8'h00 :                                  // see RQ9
                  aluRes;
   wire       wWe    = isClrAcc || (isByteOp && !destFile);// see RQ12
   wire [7:0] wWdata = isClrAcc ? 8'h00 : aluRes;          // see RQ8
   // Bit ops and the decrement leave the zero flag alone
   wire       zWe    = isClrAcc || isClrFile || isInvert;  // see RQ13
   wire       zVal   = isInvert ? (invRes == 8'h00) : 1'b1;

   wire [12:0] callDest = {pcLatch[4:3], callTarget};      // see RQ7
   wire [WDOG_PRESC_W-1:0] prescFull = '1;

   // Write channel decode
   wire        awTaken = s_axi_awvalid && s_axi_awready;
   wire        wTaken  = s_axi_wvalid && s_axi_wready;
   wire        doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire        wSelCtrl = awAddrQ == ADDR_CTRL;
   wire        wSelW    = awAddrQ == ADDR_WREG;
   wire        wSelPc   = awAddrQ == ADDR_PC;
   wire        wSelLat  = awAddrQ == ADDR_PC_LATCH;
   wire        wSelRo   = (awAddrQ == ADDR_STATUS)
                       || (awAddrQ == ADDR_WDOG)
                       || (awAddrQ == ADDR_STACK);
   wire        wFile    = awAddrQ[11:9] == FILE_REGION;
   wire        wProg    = awAddrQ[11] && ({1'b0, awAddrQ[10:2]} < PROG_LIMIT);
   // Code, file, W and PC registers take bus writes only while halted
   wire        wHaltOnly = wSelW || wSelPc || wFile || wProg;
   wire        wMapped   = wSelCtrl || wSelLat || wSelRo || wHaltOnly;
   wire        wrErr     = !wMapped || (wHaltOnly && running);
   wire        wrOk      = doWrite && !wrErr;
   wire [31:0] wdMerge   = mergeStrb(32'h0000_0000, wDataQ, wStrbQ);
   wire [6:0]  wFileIdx  = awAddrQ[8:2];
   wire [PROG_AW-1:0] wProgIdx = awAddrQ[2 +: PROG_AW];
   wire [31:0] fileMerge = mergeStrb(32'(fileMem[wFileIdx]), wDataQ, wStrbQ);
   wire [31:0] progMerge = mergeStrb(32'(progMem[wProgIdx]), wDataQ, wStrbQ);

   wire next_bvalid = doWrite ? 1'b1
                    : (s_axi_bvalid && s_axi_bready) ? 1'b0 : s_axi_bvalid;
   wire next_awHeld = awTaken ? 1'b1 : (doWrite ? 1'b0 : awHeld);
   wire next_wHeld  = wTaken ? 1'b1 : (doWrite ? 1'b0 : wHeld);

   // Read channel decode
   wire        arTaken = s_axi_arvalid && s_axi_arready;
   wire        rFile   = s_axi_araddr[11:9] == FILE_REGION;
   wire        rProg   = s_axi_araddr[11]
                      && ({1'b0, s_axi_araddr[10:2]} < PROG_LIMIT);
   wire [7:0]  rFileVal = fileMem[s_axi_araddr[8:2]];
   wire [13:0] rProgVal = progMem[s_axi_araddr[2 +: PROG_AW]];
   wire [12:0] stackTop = stackMem[sp - SP_W'(1)];
   wire [31:0] statusVal = 32'({running, powerdownFlag, timeoutFlag,
                                zeroFlag});
   wire [31:0] rdValue =
      (s_axi_araddr == ADDR_CTRL)   ? 32'(running) :
      (s_axi_araddr == ADDR_STATUS) ? statusVal :
      (s_axi_araddr == ADDR_WREG)   ? 32'(wReg) :
      (s_axi_araddr == ADDR_PC)     ? 32'(pc) :
      (s_axi_araddr == ADDR_PC_LATCH) ? 32'(pcLatch) :
      (s_axi_araddr == ADDR_WDOG)   ? 32'({wdogPresc, wdogCount}) :
      (s_axi_araddr == ADDR_STACK)  ? {3'h0, stackTop, 16'(sp)} :
      rFile                         ? 32'(rFileVal) :
      rProg                         ? 32'(rProgVal) : 32'h0000_0000;
   wire        rdMapped = rFile || rProg
                       || (s_axi_araddr == ADDR_CTRL)
                       || (s_axi_araddr == ADDR_STATUS)
                       || (s_axi_araddr == ADDR_WREG)
                       || (s_axi_araddr == ADDR_PC)
                       || (s_axi_araddr == ADDR_PC_LATCH)
                       || (s_axi_araddr == ADDR_WDOG)
                       || (s_axi_araddr == ADDR_STACK);
   wire        next_rvalid = arTaken ? 1'b1
                           : (s_axi_rvalid && s_axi_rready) ? 1'b0
                           : s_axi_rvalid;

   // Write path
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddrQ       <= 12'h000;
         wDataQ        <= 32'h0000_0000;
         wStrbQ        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (awTaken) begin
            awAddrQ <= s_axi_awaddr;
         end
         if (wTaken) begin
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
         end
         awHeld        <= next_awHeld;
         wHeld         <= next_wHeld;
         s_axi_bvalid  <= next_bvalid;
         s_axi_awready <= !next_awHeld && !next_bvalid;
         s_axi_wready  <= !next_wHeld && !next_bvalid;
      end
   end

   // Read path
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
      end else begin
         if (arTaken) begin
            s_axi_rdata <= rdValue;
            s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end
         s_axi_rvalid  <= next_rvalid;
         s_axi_arready <= !next_rvalid;
      end
   end

   // Run control and instruction cycle phase
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         running <= 1'b0;
         phase   <= 2'h0;
         pcLatch <= PC_LATCH_RESET;
      end else begin
         if (wrOk && wSelCtrl) begin
            running <= wdMerge[CTRL_RUN];
         end
         if (wrOk && wSelLat) begin
            pcLatch <= wdMerge[4:0];
         end
         phase <= (!running || cycleEnd) ? 2'h0 : phase + 2'h1;  // see RQ16
      end
   end

   // Fetch, skip and call sequencing
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pc         <= PC_RESET;
         instrReg   <= 14'h0000;
         instrValid <= 1'b0;
         sp         <= '0;
      end else if (wrOk && wSelPc) begin
         pc         <= wdMerge[12:0];
         instrValid <= 1'b0;
      end else if (cycleEnd) begin
         if (isCall) begin
            // Prefetched word is dropped; the next slot is a no-operation
            pc         <= callDest;                          // see RQ7
            instrValid <= 1'b0;
            sp         <= sp + SP_W'(1);
         end else begin
            instrReg   <= progMem[pc[PROG_AW-1:0]];          // see RQ15
            pc         <= pc + 13'h0001;
            instrValid <= !skipNow;                          // see RQ6
         end
      end
   end

   // Working register and zero flag
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wReg     <= W_RESET;
         zeroFlag <= ZERO_RESET;
      end else begin
         if (wrOk && wSelW) begin
            wReg <= wdMerge[7:0];
         end else if (wWe) begin
            wReg <= wWdata;                                  // see RQ8
         end
         if (zWe) begin
            zeroFlag <= zVal;                                // see RQ9 see RQ11
         end
      end
   end

   // Watchdog: prescaler counts instruction cycles, counter its wraps.
   // A counter wrap only clears the time-out flag; the chip-level reset
   // it would cause lies outside this block.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wdogCount     <= 8'h00;
         wdogPresc     <= '0;
         timeoutFlag   <= TIMEOUT_RESET;
         powerdownFlag <= PWRDOWN_RESET;
      end else if (isWdogClr) begin
         wdogCount     <= 8'h00;                             // see RQ10
         wdogPresc     <= '0;
         timeoutFlag   <= 1'b1;
         powerdownFlag <= 1'b1;
      end else if (cycleEnd) begin
         wdogPresc <= wdogPresc + WDOG_PRESC_W'(1);
         if (wdogPresc == prescFull) begin
            wdogCount <= wdogCount + 8'h01;
            if (wdogCount == 8'hFF) begin
               timeoutFlag <= 1'b0;
            end
         end
      end
   end

   // Arrays carry no reset; software loads the code and file arrays while halted
   always_ff @(posedge clk_sys) begin
      if (fileWe) begin
         fileMem[fileAddr] <= fileWdata;                     // see RQ1 see RQ2
      end else if (wrOk && wFile) begin
         fileMem[wFileIdx] <= fileMerge[7:0];
      end
      if (wrOk && wProg) begin
         progMem[wProgIdx] <= progMerge[13:0];
      end
      if (isCall && cycleEnd) begin
         stackMem[sp] <= pc;                                 // see RQ7
      end
   end

endmodule // bscd_core
`default_nettype wire

// file: design/bscd_pkg.sv
// Behaviour
// RQ1 - The bit clear instruction forces the selected bit of the addressed file register to zero and touches no flag.
// RQ2 - The bit set instruction forces the selected bit of the addressed file register to one and touches no flag.
// RQ3 - Bit instructions carry a 7-bit file address (0 to 127) and a 3-bit bit selector (0 to 7).
// RQ4 - The test-and-skip-if-zero instruction skips the next instruction when the selected bit reads zero.
// RQ5 - The test-and-skip-if-one instruction skips the next instruction when the selected bit reads one.
// RQ6 - A skip discards the prefetched instruction and runs a no-operation in its slot, so it costs two cycles.
// RQ7 - A call pushes the incremented program counter, loads the 11-bit target into PC<10:0> and latch bits 4:3 into PC<12:11>, in two cycles.
// RQ8 - The clear-accumulator instruction loads zero into the working register and sets the zero flag, ignoring its low bits.
// RQ9 - The clear-file instruction writes zero into the addressed file register and sets the zero flag in one cycle.
// RQ10 - The watchdog clear instruction zeroes the watchdog counter and prescaler and sets the time-out and power-down flags.
// RQ11 - The invert instruction forms the bitwise complement of the addressed register and updates the zero flag from it.
// RQ12 - For byte instructions a destination bit of 0 sends the result to the working register and 1 back to the file register.
// RQ13 - The decrement-skip instruction decrements the addressed register into the chosen destination and changes no flag.
// RQ14 - When that decrement gives zero the prefetched instruction is discarded and a no-operation runs instead.
// RQ15 - Each instruction is one 14-bit word: an opcode field followed by its operand fields.
// RQ16 - One instruction cycle spans four oscillator periods and single-cycle instructions finish within one.
// RQ17 - Skip decisions use the register value read in the skipping instruction's own execute cycle.
package bscd_pkg;

   // Register map
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_WREG   = 12'h008;
   localparam logic [11:0] ADDR_PC     = 12'h00C;
   localparam logic [11:0] ADDR_PC_LATCH = 12'h010;
   localparam logic [11:0] ADDR_WDOG   = 12'h014;
   localparam logic [11:0] ADDR_STACK  = 12'h018;
   localparam logic [2:0]  FILE_REGION = 3'h1;
   localparam int          CTRL_RUN    = 0;
   localparam int          ST_ZERO     = 0;
   localparam int          ST_TIMEOUT  = 1;
   localparam int          ST_PWRDOWN  = 2;
   localparam int          ST_RUNNING  = 3;

   // Reset values
   localparam logic [7:0]  W_RESET      = 8'h00;
   localparam logic [12:0] PC_RESET     = 13'h0000;
   localparam logic [4:0]  PC_LATCH_RESET = 5'h00;
   localparam logic        ZERO_RESET     = 1'b0;
   localparam logic        TIMEOUT_RESET  = 1'b1;
   localparam logic        PWRDOWN_RESET  = 1'b1;

   // Instruction cycle length in oscillator periods
   localparam int          OSC_PER_INSTR = 4;
   localparam logic [1:0]  PHASE_LAST    = 2'(OSC_PER_INSTR - 1);

   // Opcode fields of the 14-bit instruction word
   localparam int          INSTR_W        = 14;
   localparam logic [3:0]  OPC_BIT_CLEAR  = 4'h4;
   localparam logic [3:0]  OPC_BIT_SET    = 4'h5;
   localparam logic [3:0]  OPC_TEST_ZERO  = 4'h6;
   localparam logic [3:0]  OPC_TEST_ONE   = 4'h7;
   localparam logic [2:0]  OPC_CALL       = 3'h4;
   localparam logic [6:0]  OPC_CLEAR_ACC  = 7'h02;
   localparam logic [6:0]  OPC_CLEAR_FILE = 7'h03;
   localparam logic [13:0] OPC_WDOG_CLEAR = 14'h0064;
   localparam logic [5:0]  OPC_INVERT     = 6'h09;
   localparam logic [5:0]  OPC_DEC_SKIP   = 6'h0B;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      NO_OPERATION,
      BIT_CLEAR_OP,
      BIT_SET_OP,
      TEST_SKIP_IF_ZERO_OP,
      TEST_SKIP_IF_ONE_OP,
      CALL_OP,
      CLEAR_ACCUMULATOR_OP,
      CLEAR_FILE_OP,
      WATCHDOG_CLEAR_OP,
      INVERT_FILE_OP,
      DECREMENT_SKIP_ZERO_OP
   } bscd_op_t;

   function automatic logic [7:0] bitMask(input logic [2:0] sel);
      bitMask = 8'h01 << sel;
   endfunction

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      mergeStrb = res;
   endfunction

endpackage

// file: design/bscd_decode.sv
`timescale 1ns/10ps
`default_nettype none
module bscd_decode
   import bscd_pkg::*;
(
   input  wire logic [13:0] instr,
   output bscd_op_t         op,
   output logic [6:0]       fileAddr,
   output logic [2:0]       bitSel,
   output logic             destFile,
   output logic [10:0]      callTarget
);

   // Fields sit at fixed places in the one-word instruction
   assign fileAddr   = instr[6:0];   // see RQ3 see RQ15
   assign bitSel     = instr[9:7];   // see RQ3
   assign destFile   = instr[7];     // see RQ12
   assign callTarget = instr[10:0];

   assign op =
      (instr[13:10] == OPC_BIT_CLEAR)  ? BIT_CLEAR_OP :
      (instr[13:10] == OPC_BIT_SET)    ? BIT_SET_OP :
      (instr[13:10] == OPC_TEST_ZERO)  ? TEST_SKIP_IF_ZERO_OP :
      (instr[13:10] == OPC_TEST_ONE)   ? TEST_SKIP_IF_ONE_OP :
      (instr[13:11] == OPC_CALL)       ? CALL_OP :
      // Low seven bits are don't-care for the accumulator clear
      (instr[13:7] == OPC_CLEAR_ACC)   ? CLEAR_ACCUMULATOR_OP :  // see RQ8
      (instr[13:7] == OPC_CLEAR_FILE)  ? CLEAR_FILE_OP :
      (instr == OPC_WDOG_CLEAR)        ? WATCHDOG_CLEAR_OP :
      (instr[13:8] == OPC_INVERT)      ? INVERT_FILE_OP :
      (instr[13:8] == OPC_DEC_SKIP)    ? DECREMENT_SKIP_ZERO_OP :
                                         NO_OPERATION;

endmodule // bscd_decode
`default_nettype wire

// file: test/bscd_chk.sv
`timescale 1ns/10ps
`default_nettype none
module bscd_chk
   import bscd_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        arst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("late write response");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("late read response");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready while rvalid");
   a_write_busy: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("ready while bvalid");
   // Upper space is unmapped, so software gets an error, not stale data
   a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr >= 12'hC00 |=> s_axi_rresp == RESP_SLVERR &&
      s_axi_rdata == 32'h0000_0000) else $error("unmapped read ok");
   a_ready_return: assert property (s_axi_bvalid && s_axi_bready |=>
      s_axi_awready && s_axi_wready) else $error("write ready stuck");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_refused: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // bscd_chk
bind bscd_core bscd_chk bscd_chk_inst (.clk_sys(clk_sys), .arst_n(arst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import bscd_pkg::*;
;
   logic        clk_sys = 1'b0, arst_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          error_cnt = 0, checks_done = 0, cyc = 0;
   bscd_core bscd_core_inst (.clk_sys(clk_sys), .arst_n(arst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("[ERR] %0t run hung", $time);
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [11:0] fa(input logic [6:0] f);
      return 12'h200 | {3'h0, f, 2'h0};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = RESP_OKAY);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge clk_sys);
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   // Mask lets free-running counts be bounded rather than pinned
   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                     input logic [1:0] er = RESP_OKAY,
                     input logic [31:0] m = 32'hFFFF_FFFF);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b1;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata & m, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // Tail of every program is no-operation padding laid down at start
   task automatic run_prog(input logic [13:0] p[8]);
      for (int i = 0; i < 8; i++) begin
         wr(12'h800 | 12'(i * 4), {18'h0, p[i]});
      end
      wr(ADDR_PC, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0001);
      wr(ADDR_WREG, 32'h0000_0000, RESP_SLVERR);
      repeat (48) @(posedge clk_sys);
      wr(ADDR_CTRL, 32'h0000_0000);
   endtask
   task automatic t_reset();
      rd(ADDR_STATUS, 32'h0000_0006);
      rd(ADDR_WREG, 32'h0000_0000);
      rd(12'hFFC, 32'h0000_0000, RESP_SLVERR);
      for (int i = 0; i < 64; i++) begin
         wr(12'h800 | 12'(i * 4), 32'h0000_0000);
      end
      $display("reset test done");
   endtask
   task automatic t_bits();
      wr(fa(7'h05), 32'h0000_00C7);
      wr(fa(7'h7F), 32'h0000_000A);
      wr(fa(7'h00), 32'h0000_00FF);
      run_prog('{{OPC_BIT_CLEAR, 3'h7, 7'h05}, {OPC_BIT_SET, 3'h7, 7'h7F},
                 {OPC_BIT_CLEAR, 3'h0, 7'h00}, 14'h0, 14'h0, 14'h0, 14'h0,
                 14'h0});
      rd(fa(7'h05), 32'h0000_0047);
      rd(fa(7'h7F), 32'h0000_008A);
      rd(fa(7'h00), 32'h0000_00FE);
      rd(ADDR_STATUS, 32'h0000_0006);
      $display("bit test done");
   endtask
   task automatic t_skip();
      wr(fa(7'h10), 32'h0000_0002);
      wr(fa(7'h11), 32'h0000_0000);
      run_prog('{{OPC_TEST_ZERO, 3'h0, 7'h10}, {OPC_BIT_SET, 3'h0, 7'h11},
                 {OPC_TEST_ZERO, 3'h1, 7'h10}, {OPC_BIT_SET, 3'h1, 7'h11},
                 {OPC_TEST_ONE, 3'h1, 7'h10}, {OPC_BIT_SET, 3'h2, 7'h11},
                 {OPC_TEST_ONE, 3'h0, 7'h10}, {OPC_BIT_SET, 3'h3, 7'h11}});
      rd(fa(7'h11), 32'h0000_000A);
      $display("skip test done");
   endtask
   task automatic t_byte();
      wr(fa(7'h20), 32'h0000_0013);
      wr(fa(7'h21), 32'h0000_005A);
      wr(fa(7'h22), 32'h0000_0000);
      run_prog('{{OPC_INVERT, 1'b0, 7'h20}, {OPC_INVERT, 1'b1, 7'h22},
                 {OPC_CLEAR_FILE, 7'h21}, 14'h0, 14'h0, 14'h0, 14'h0, 14'h0});
      rd(ADDR_WREG, 32'h0000_00EC);
      rd(fa(7'h20), 32'h0000_0013);
      rd(fa(7'h22), 32'h0000_00FF);
      rd(fa(7'h21), 32'h0000_0000);
      rd(ADDR_STATUS, 32'h0000_0007);
      $display("byte test done");
   endtask
   task automatic t_dec();
      wr(fa(7'h30), 32'h0000_0002);
      wr(fa(7'h31), 32'h0000_0001);
      wr(fa(7'h32), 32'h0000_0000);
      wr(fa(7'h33), 32'h0000_0000);
      run_prog('{{OPC_INVERT, 1'b1, 7'h33}, {OPC_DEC_SKIP, 1'b1, 7'h31},
                 {OPC_BIT_SET, 3'h1, 7'h32}, {OPC_DEC_SKIP, 1'b0, 7'h30},
                 {OPC_BIT_SET, 3'h0, 7'h32}, 14'h0, 14'h0, 14'h0});
      rd(fa(7'h31), 32'h0000_0000);
      rd(fa(7'h30), 32'h0000_0002);
      rd(ADDR_WREG, 32'h0000_0001);
      rd(fa(7'h32), 32'h0000_0001);
      rd(ADDR_STATUS, 32'h0000_0006);
      $display("decrement test done");
   endtask
   task automatic t_call();
      wr(ADDR_WREG, 32'h0000_005A);
      wr(ADDR_PC_LATCH, 32'h0000_0018);
      run_prog('{OPC_WDOG_CLEAR, {OPC_CLEAR_ACC, 7'h55},
                 {OPC_CALL, 11'h123}, 14'h0, 14'h0, 14'h0, 14'h0, 14'h0});
      rd(ADDR_WREG, 32'h0000_0000);
      rd(ADDR_STATUS, 32'h0000_0007);
      rd(ADDR_WDOG, 32'h0000_0000, RESP_OKAY, 32'h0000_F0FF);
      rd(ADDR_STACK, 32'h0003_0001);
      rd(ADDR_PC, 32'h0000_1920, RESP_OKAY, 32'h0000_1FF0);
      $display("call test done");
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_bits();
      t_skip();
      t_byte();
      t_dec();
      t_call();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
